/* include/sensor_timing_pkg.sv */
// Purpose: shared constants and carriers for the sensor reset and frame strobe block
// Assumes: one clock at 250 MHz, register port with 8-bit address and 16-bit data
// Notes:   offsets are word indices on the plain register port
package sensor_timing_pkg;

    // register offsets
    localparam logic [7:0] CORE_RESET_OFFSET   = 8'h0d;
    localparam logic [7:0] STROBE_EDGE_OFFSET  = 8'h1f;
    localparam logic [7:0] ROW_WIDTH_OFFSET    = 8'h03;
    localparam logic [7:0] ACTIVE_ROWS_OFFSET  = 8'h04;
    localparam logic [7:0] HORZ_BLANK_OFFSET   = 8'h05;
    localparam logic [7:0] VERT_BLANK_OFFSET   = 8'h06;
    localparam logic [7:0] INTEG_ROWS_OFFSET   = 8'h09;
    localparam logic [7:0] FRAME_STATUS_OFFSET = 8'h0a;
    localparam logic [7:0] FRAME_COUNT_OFFSET  = 8'h0b;
    // window that the host must leave alone during standby
    localparam logic [7:0] STANDBY_GUARD_LO    = 8'hf7;
    localparam logic [7:0] STANDBY_GUARD_HI    = 8'hfd;

    // core reset register fields
    localparam int SOFT_RESET_BIT = 0;
    localparam int RESTART_BIT    = 1;
    localparam int STANDBY_BIT    = 2;

    // frame strobe edge register fields
    localparam int FALL_ENABLE_BIT = 15;
    localparam int FALL_ROWS_LSB   = 8;
    localparam int RISE_ENABLE_BIT = 7;
    localparam int RISE_ROWS_LSB   = 0;
    localparam int EDGE_ROWS_WIDTH = 7;

    // values after reset
    localparam logic [15:0] STROBE_EDGE_RESET = 16'h0000;
    localparam logic [15:0] ROW_WIDTH_RESET   = 16'h0040;
    localparam logic [15:0] ACTIVE_ROWS_RESET = 16'h0030;
    localparam logic [15:0] HORZ_BLANK_RESET  = 16'h0010;
    localparam logic [15:0] VERT_BLANK_RESET  = 16'h0008;
    localparam logic [15:0] INTEG_ROWS_RESET  = 16'h0004;

    // edge placement counts in pixel clocks
    localparam logic [31:0] DEFAULT_EDGE_CLOCKS = 32'h0000_0006;
    localparam logic [31:0] EDGE_CONSTANT       = 32'h0000_0003;

    typedef enum {
        ST_HALT,
        ST_STANDBY,
        ST_INTEGRATE,
        ST_LEAD,
        ST_ACTIVE,
        ST_TAIL,
        ST_VBLANK
    } frame_state_type;

    // one register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wrData;
        logic        wr;
        logic        rd;
    } reg_req_type;

    // parallel pixel output
    typedef struct packed {
        logic       frameValid;
        logic       lineValid;
        logic [9:0] data;
    } pixel_out_type;

endpackage

/* hdl/sensor_frame_timing.sv */
// Purpose: soft reset, restart, standby and frame strobe edge timing of the sensor core
// Assumes: register port strobes are one cycle; pixel data input is synchronous
// Notes:   frame timing counts in pixel clocks; outputs are registered
//
// Functional notes
// - standby bit one enters low-power state
// - restart truncates frame, resets from row zero
// - first frame waits one integration time
// - restart bit self-clears, always reads zero
// - soft reset truncates frame, idles outputs
// - soft reset defaults all other registers
// - default fall six clocks after last line
// - every active row still gets line strobe
// - default rise six clocks before first line
// - early rise lead rows, blank, three
module sensor_frame_timing (
    input  wire logic                            clock,
    input  wire logic                            rst,
    input  wire sensor_timing_pkg::reg_req_type   regReq,
    output logic [15:0]                          rdData,
    input  wire logic [9:0]                      pixelIn,
    output sensor_timing_pkg::pixel_out_type     pixelOut,
    output logic                                 standbyActive,
    output logic                                 coreInReset
);
    import sensor_timing_pkg::*;

    // register state
    logic [15:0]     strobeEdge_q;
    logic [15:0]     rowWidth_q;
    logic [15:0]     activeRows_q;
    logic [15:0]     horzBlank_q;
    logic [15:0]     vertBlank_q;
    logic [15:0]     integRows_q;
    logic            softReset_q;
    logic            standby_q;
    logic [15:0]     frameCount_q;
    logic [15:0]     rdData_q;

    // frame state
    frame_state_type state_q;
    frame_state_type state_d;
    logic [31:0]     cnt_q;
    logic [31:0]     cnt_d;
    logic [31:0]     remain_q;
    logic [31:0]     remain_d;
    logic [15:0]     row_q;
    logic [15:0]     row_d;
    logic [16:0]     col_q;
    logic [16:0]     col_d;
    pixel_out_type   pixel_q;
    pixel_out_type   pixel_d;

    // decoded strobes and derived timing
    logic            resetRegWrite;
    logic            restartPulse;
    logic [31:0]     rowTime;
    logic [31:0]     riseLead;
    logic [31:0]     fallLead;
    logic [31:0]     activeSpan;
    logic [31:0]     integTime;
    logic            lastRow;
    logic            fvEarlyLow;

    // zero counts would stall the sequencer, so treat them as one
    function automatic logic [31:0] atLeastOne(input logic [31:0] value);
        atLeastOne = (value == 32'h0000_0000) ? 32'h0000_0001 : value;
    endfunction

    // lead of an early edge: (1 + rows) row times
    function automatic logic [31:0] rowsLead(input logic [6:0]  rows,
                                             input logic [31:0] rowClocks);
        logic [31:0] widened;
        widened = {25'h0000000, rows} + 32'h0000_0001;
        rowsLead = 32'(widened * rowClocks);
    endfunction

    function automatic logic [15:0] widen1(input logic bitValue);
        widen1 = {15'h0000, bitValue};
    endfunction

    // register port decode
    assign resetRegWrite = regReq.wr && (regReq.addr == CORE_RESET_OFFSET);
    // write-one action
    // restart acts only on a one, and not while reset is being held
    assign restartPulse  = resetRegWrite && regReq.wrData[RESTART_BIT]
                           && !regReq.wrData[SOFT_RESET_BIT] && !softReset_q;

    // timing derived from the live configuration
    assign rowTime    = atLeastOne({16'h0000, rowWidth_q} + {16'h0000, horzBlank_q});
    assign activeSpan = 32'(32'(({16'h0000, atLeastOne({16'h0000, activeRows_q})} - 32'h1)
                        * rowTime) + atLeastOne({16'h0000, rowWidth_q}));
    assign integTime  = atLeastOne(32'({16'h0000, integRows_q} * rowTime));
    assign lastRow    = (row_q == 16'(atLeastOne({16'h0000, activeRows_q}) - 32'h1));

    assign riseLead = strobeEdge_q[RISE_ENABLE_BIT]
        ? 32'(rowsLead(strobeEdge_q[RISE_ROWS_LSB +: EDGE_ROWS_WIDTH], rowTime)
              + {16'h0000, horzBlank_q} + EDGE_CONSTANT)
        : DEFAULT_EDGE_CLOCKS;

    assign fallLead = strobeEdge_q[FALL_ENABLE_BIT]
        ? 32'(rowsLead(strobeEdge_q[FALL_ROWS_LSB +: EDGE_ROWS_WIDTH], rowTime)
              + EDGE_CONSTANT)
        : 32'h0000_0000;

    // early fall test
    // a lead longer than the span simply keeps the strobe low all through the rows
    assign fvEarlyLow = strobeEdge_q[FALL_ENABLE_BIT] && (remain_q <= fallLead);

    // reset register: soft reset and standby bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            softReset_q <= 1'b0;
            standby_q   <= 1'b0;
        end else begin
            if (resetRegWrite) begin
                softReset_q <= regReq.wrData[SOFT_RESET_BIT];
            end
            if (softReset_q || (resetRegWrite && regReq.wrData[SOFT_RESET_BIT])) begin
                standby_q <= 1'b0;
            end else if (resetRegWrite) begin
                standby_q <= regReq.wrData[STANDBY_BIT];
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strobeEdge_q <= STROBE_EDGE_RESET;
            rowWidth_q   <= ROW_WIDTH_RESET;
            activeRows_q <= ACTIVE_ROWS_RESET;
            horzBlank_q  <= HORZ_BLANK_RESET;
            vertBlank_q  <= VERT_BLANK_RESET;
            integRows_q  <= INTEG_ROWS_RESET;
        end else if (softReset_q) begin
            strobeEdge_q <= STROBE_EDGE_RESET;
            rowWidth_q   <= ROW_WIDTH_RESET;
            activeRows_q <= ACTIVE_ROWS_RESET;
            horzBlank_q  <= HORZ_BLANK_RESET;
            vertBlank_q  <= VERT_BLANK_RESET;
            integRows_q  <= INTEG_ROWS_RESET;
        end else if (regReq.wr) begin
            unique case (regReq.addr)
                STROBE_EDGE_OFFSET: strobeEdge_q <= regReq.wrData;
                // host keeps fall rows in range
                ROW_WIDTH_OFFSET:   rowWidth_q   <= regReq.wrData;
                ACTIVE_ROWS_OFFSET: activeRows_q <= regReq.wrData;
                HORZ_BLANK_OFFSET:  horzBlank_q  <= regReq.wrData;
                VERT_BLANK_OFFSET:  vertBlank_q  <= regReq.wrData;
                INTEG_ROWS_OFFSET:  integRows_q  <= regReq.wrData;
                default: ;
            endcase
        end
    end

    // completed frame counter, shown to software
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frameCount_q <= 16'h0000;
        end else if (softReset_q) begin
            frameCount_q <= 16'h0000;
        end else if (state_q == ST_TAIL && state_d == ST_VBLANK) begin
            frameCount_q <= 16'(frameCount_q + 16'h0001);
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData_q <= 16'h0000;
        end else if (regReq.rd) begin
            unique case (regReq.addr)
                CORE_RESET_OFFSET:   rdData_q <= widen1(softReset_q)
                                             | (widen1(standby_q) << STANDBY_BIT);
                STROBE_EDGE_OFFSET:  rdData_q <= strobeEdge_q;
                ROW_WIDTH_OFFSET:    rdData_q <= rowWidth_q;
                ACTIVE_ROWS_OFFSET:  rdData_q <= activeRows_q;
                HORZ_BLANK_OFFSET:   rdData_q <= horzBlank_q;
                VERT_BLANK_OFFSET:   rdData_q <= vertBlank_q;
                INTEG_ROWS_OFFSET:   rdData_q <= integRows_q;
                FRAME_STATUS_OFFSET: rdData_q <= {row_q[11:0], pixel_q.frameValid,
                                                  pixel_q.lineValid, standby_q,
                                                  softReset_q};
                FRAME_COUNT_OFFSET:  rdData_q <= frameCount_q;
                // guard window unmapped here
                // unmapped addresses, the standby guard window among them, read zero
                default:             rdData_q <= 16'h0000;
            endcase
        end else begin
            rdData_q <= 16'h0000;
        end
    end

    // frame sequencer next state
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        remain_d = remain_q;
        row_d    = row_q;
        col_d    = col_q;
        if (softReset_q) begin
            state_d  = ST_HALT;
            cnt_d    = 32'h0000_0000;
            remain_d = 32'h0000_0000;
            row_d    = 16'h0000;
            col_d    = 17'h00000;
        end else if (standby_q) begin
            state_d  = ST_STANDBY;
            cnt_d    = 32'h0000_0000;
            row_d    = 16'h0000;
            col_d    = 17'h00000;
        end else if (restartPulse || state_q == ST_HALT || state_q == ST_STANDBY) begin
            state_d  = ST_INTEGRATE;
            cnt_d    = integTime;
            row_d    = 16'h0000;
            col_d    = 17'h00000;
        end else begin
            unique case (state_q)
                ST_INTEGRATE: begin
                    if (cnt_q <= 32'h0000_0001) begin
                        state_d = ST_LEAD;
                        cnt_d   = atLeastOne(riseLead);
                    end else begin
                        cnt_d = cnt_q - 32'h0000_0001;
                    end
                end
                ST_LEAD: begin
                    if (cnt_q <= 32'h0000_0001) begin
                        state_d  = ST_ACTIVE;
                        remain_d = activeSpan;
                        row_d    = 16'h0000;
                        col_d    = 17'h00000;
                    end else begin
                        cnt_d = cnt_q - 32'h0000_0001;
                    end
                end
                ST_ACTIVE: begin
                    remain_d = remain_q - 32'h0000_0001;
                    if (lastRow && {15'h0000, col_q} == atLeastOne({16'h0000, rowWidth_q})
                                                        - 32'h0000_0001) begin
                        state_d = ST_TAIL;
                        cnt_d   = DEFAULT_EDGE_CLOCKS;
                    end else if ({15'h0000, col_q} == rowTime - 32'h0000_0001) begin
                        col_d = 17'h00000;
                        row_d = 16'(row_q + 16'h0001);
                    end else begin
                        col_d = 17'(col_q + 17'h00001);
                    end
                end
                ST_TAIL: begin
                    if (cnt_q <= 32'h0000_0001) begin
                        state_d = ST_VBLANK;
                        cnt_d   = atLeastOne({16'h0000, vertBlank_q});
                    end else begin
                        cnt_d = cnt_q - 32'h0000_0001;
                    end
                end
                ST_VBLANK: begin
                    if (cnt_q <= 32'h0000_0001) begin
                        state_d = ST_LEAD;
                        cnt_d   = atLeastOne(riseLead);
                    end else begin
                        cnt_d = cnt_q - 32'h0000_0001;
                    end
                end
                default: begin
                    state_d = ST_INTEGRATE;
                    cnt_d   = integTime;
                end
            endcase
        end
    end

    // pixel port next value, idle outside frames
    always_comb begin
        pixel_d = '0;
        unique case (state_q)
            ST_LEAD: begin
                pixel_d.frameValid = 1'b1;
            end
            ST_ACTIVE: begin
                pixel_d.frameValid = !fvEarlyLow;
                pixel_d.lineValid  = ({15'h0000, col_q} < {16'h0000, rowWidth_q});
                pixel_d.data       = pixel_d.lineValid ? pixelIn : 10'h000;
            end
            ST_TAIL: begin
                pixel_d.frameValid = !strobeEdge_q[FALL_ENABLE_BIT];
            end
            default: ;
        endcase
        if (softReset_q || standby_q) begin
            pixel_d = '0;
        end
    end

    // sequencer state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q  <= ST_HALT;
            cnt_q    <= 32'h0000_0000;
            remain_q <= 32'h0000_0000;
            row_q    <= 16'h0000;
            col_q    <= 17'h00000;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            remain_q <= remain_d;
            row_q    <= row_d;
            col_q    <= col_d;
        end
    end

    // registered pixel port; one cycle behind the sequencer for clean edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pixel_q <= '0;
        end else begin
            pixel_q <= pixel_d;
        end
    end

    assign pixelOut      = pixel_q;
    assign rdData        = rdData_q;
    assign standbyActive = standby_q;
    assign coreInReset   = softReset_q;

endmodule

/* verif/sensor_frame_timing_checker.sv */
// Purpose: concurrent checks on the ports of the reset and frame strobe block
// Assumes: single clock domain, strobes one cycle long
// Notes:   edgeQ shadows the strobe edge register so the rise check knows its mode
module sensor_frame_timing_checker (
    input wire logic                            clock,
    input wire logic                            rst,
    input wire sensor_timing_pkg::reg_req_type   regReq,
    input wire logic [15:0]                     rdData,
    input wire logic [9:0]                      pixelIn,
    input wire sensor_timing_pkg::pixel_out_type pixelOut,
    input wire logic                            standbyActive,
    input wire logic                            coreInReset
);
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_timing_pkg::*;
    logic        ctrlWr;
    logic [15:0] edgeQ;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    assign ctrlWr = regReq.wr && regReq.addr == CORE_RESET_OFFSET;

    // shadow copy; soft reset wipes it like the real register
    always_ff @(posedge clock or posedge rst) begin
        if (rst || coreInReset) begin
            edgeQ <= 16'h0000;
        end else if (regReq.wr && regReq.addr == STROBE_EDGE_OFFSET) begin
            edgeQ <= regReq.wrData;
        end
    end

    rd_idle_a: assert property (!regReq.rd |=> rdData == 16'h0000)
        else $error("read data not idle");
    restart_reads_a: assert property (regReq.rd && regReq.addr == CORE_RESET_OFFSET |=>
        !rdData[RESTART_BIT]) else $error("restart bit read back as one");
    soft_flag_a: assert property (ctrlWr |=> coreInReset == $past(regReq.wrData[0]))
        else $error("soft reset flag wrong");
    standby_flag_a: assert property (ctrlWr && !coreInReset && !regReq.wrData[0] |=>
        standbyActive == $past(regReq.wrData[2])) else $error("standby flag wrong");
    soft_idle_a: assert property (coreInReset && $past(coreInReset) |-> pixelOut == '0)
        else $error("outputs busy in soft reset");
    standby_idle_a: assert property (standbyActive && $past(standbyActive) |-> pixelOut == '0)
        else $error("outputs busy in standby");
    defaults_held_a: assert property (coreInReset && regReq.rd &&
        regReq.addr == STROBE_EDGE_OFFSET |=> rdData == STROBE_EDGE_RESET)
        else $error("edge register not at default in soft reset");
    restart_cut_a: assert property (ctrlWr && regReq.wrData[1] && !regReq.wrData[0] &&
        !coreInReset |-> ##[1:3] !pixelOut.frameValid && !pixelOut.lineValid)
        else $error("restart did not cut the frame");
    rise_default_a: assert property ($rose(pixelOut.frameValid) && !edgeQ[7] |->
        (!pixelOut.lineValid) [*6] ##1 (pixelOut.lineValid || !pixelOut.frameValid))
        else $error("default frame rise lead wrong");
    row_data_a: assert property (pixelOut.data ==
        (pixelOut.lineValid ? $past(pixelIn) : 10'h000)) else $error("row data wrong");

    cover property ($rose(pixelOut.frameValid));
    cover property (ctrlWr && regReq.wrData[1]);
    cover property ($fell(pixelOut.frameValid) && pixelOut.lineValid);
endmodule

bind sensor_frame_timing sensor_frame_timing_checker checker_u (.clock(clock), .rst(rst),
    .regReq(regReq), .rdData(rdData), .pixelIn(pixelIn), .pixelOut(pixelOut),
    .standbyActive(standbyActive), .coreInReset(coreInReset));

/* verif/pixel_capture_model.sv */
// Purpose: host capture side that measures strobe spacing of each frame
// Assumes: frame and row strobes registered in the clock domain
// Notes:   riseGap, lineCount and lvAfterFall restart at each frame rise, so read them before the next one
module pixel_capture_model (
    input  wire logic                             clock,
    input  wire logic                             rst,
    input  wire sensor_timing_pkg::pixel_out_type pixelOut,
    output logic [15:0]                           riseGap,
    output logic [15:0]                           fallGap,
    output logic [15:0]                           lineCount,
    output logic [15:0]                           lvAfterFall,
    output logic [15:0]                           frames
);
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_timing_pkg::*;
    logic        fvQ;
    logic        lvQ;
    logic        seenLine;
    logic [15:0] tailCnt;

    // rows after an early fall still belong to the frame just ended
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {riseGap, fallGap, lineCount, lvAfterFall, frames, tailCnt} <= '0;
            {fvQ, lvQ, seenLine} <= '0;
        end else begin
            fvQ <= pixelOut.frameValid;
            lvQ <= pixelOut.lineValid;
            if (pixelOut.frameValid && !fvQ) begin
                {lineCount, lvAfterFall, tailCnt} <= '0;
                riseGap  <= 16'h0001;
                seenLine <= 1'b0;
            end else begin
                if (pixelOut.frameValid && !pixelOut.lineValid && !seenLine)
                    riseGap <= riseGap + 16'h0001;
                if (pixelOut.lineValid && !lvQ) lineCount <= lineCount + 16'h0001;
                if (pixelOut.lineValid) seenLine <= 1'b1;
                if (pixelOut.lineValid && !pixelOut.frameValid)
                    lvAfterFall <= lvAfterFall + 16'h0001;
                if (pixelOut.lineValid) tailCnt <= 16'h0000;
                else if (pixelOut.frameValid && seenLine) tailCnt <= tailCnt + 16'h0001;
                if (!pixelOut.frameValid && fvQ) begin
                    fallGap <= tailCnt;
                    frames  <= frames + 16'h0001;
                end
            end
        end
    end
endmodule

/* verif/sensor_frame_timing_test.sv */
// Purpose: self-checking bench for soft reset, restart, standby and strobe edges
// Assumes: short frames set up through the register port, row time 12 clocks
// Notes:   vertical blank widened so late rows are counted before the next rise
module sensor_frame_timing_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sensor_timing_pkg::*;
    logic          clock;
    logic          rst;
    reg_req_type   regReq;
    logic [9:0]    pixelIn;
    logic [15:0]   rdData;
    pixel_out_type pixelOut;
    logic          standbyActive;
    logic          coreInReset;
    logic [15:0]   riseGap, fallGap, lineCount, lvAfterFall, frames, rd, ev;
    logic [1:0]    r, f;
    int            error_cnt, n_compared, seed, cnt;
    logic [7:0]    addrs [9] = '{8'h0d, 8'h1f, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h20, 8'hf7};
    logic [15:0]   resets [9] = '{16'h0, 16'h0, 16'h40, 16'h30, 16'h10, 16'h8, 16'h4, 16'h0, 16'h0};

    sensor_frame_timing dut_u (.clock(clock), .rst(rst), .regReq(regReq), .rdData(rdData),
        .pixelIn(pixelIn), .pixelOut(pixelOut), .standbyActive(standbyActive),
        .coreInReset(coreInReset));
    pixel_capture_model cap_u (.clock(clock), .rst(rst), .pixelOut(pixelOut),
        .riseGap(riseGap), .fallGap(fallGap), .lineCount(lineCount),
        .lvAfterFall(lvAfterFall), .frames(frames));

    function automatic logic [15:0] rise_lead(input logic [1:0] rows);
        return (16'h0001 + 16'(rows)) * 16'h000c + 16'h0004 + 16'h0003;
    endfunction
    function automatic logic [15:0] fall_lead(input logic [1:0] rows);
        return (16'h0001 + 16'(rows)) * 16'h000c + 16'h0003;
    endfunction

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic compare_val(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask
    task automatic give_up();
        $display("ERROR wait bound expired");
        error_cnt++;
        tally_and_finish();
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        regReq.wr <= 1'b0;
        #1;
    endtask
    // read data stands only in the cycle after the strobe edge
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        regReq <= '{addr: a, wrData: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        regReq.rd <= 1'b0;
        #1 d = rdData;
    endtask
    task automatic wait_line();
        int i;
        for (i = 0; i < 20000; i++) begin
            @(posedge clock);
            #1 if (pixelOut.lineValid === 1'b1) break;
        end
        if (i == 20000) give_up();
    endtask
    // settle lets rows that outlive an early fall land in the counts
    task automatic wait_frame(input int settle);
        logic [15:0] start;
        int          i;
        start = frames;
        for (i = 0; i < 20000 && frames === start; i++) @(posedge clock);
        if (i == 20000) give_up();
        repeat (settle) @(posedge clock);
        #1;
    endtask
    task automatic run_frame(input logic [15:0] edgeVal);
        reg_write(8'h0d, 16'h0002);
        reg_read(8'h0d, rd);
        compare_val("restart bit", rd, 16'h0000);
        reg_write(8'h1f, edgeVal);
        wait_frame(30);
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) pixelIn <= 10'($random(seed));

    initial begin
        seed = 32'h34c7299a;
        error_cnt = 0;
        n_compared = 0;
        rst = 1'b1;
        regReq = '0;
        pixelIn = 10'h000;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        // guard window touched only outside standby
        for (int i = 0; i < 9; i++) begin
            reg_read(addrs[i], rd);
            compare_val("reset value", rd, resets[i]);
        end
        reg_write(8'h1f, 16'hbfff);
        reg_read(8'h1f, rd);
        compare_val("edge register", rd, 16'hbfff);
        reg_write(8'h20, 16'h1234);
        reg_read(8'h20, rd);
        compare_val("unmapped", rd, 16'h0000);
        $display("test defaults done");
        // short frames: width 8, two rows, blank 4, long vblank, three rows integration
        reg_write(8'h03, 16'h0008);
        reg_write(8'h04, 16'h0002);
        reg_write(8'h05, 16'h0004);
        reg_write(8'h06, 16'h0040);
        reg_write(8'h09, 16'h0003);
        for (int i = 0; i < 4; i++) begin
            ev = (i == 0) ? 16'h0000 : (16'($random(seed)) & 16'h077f);
            run_frame(ev);
            compare_val("default rise", riseGap, 16'h0006);
            compare_val("default fall", fallGap, 16'h0006);
            compare_val("rows", lineCount, 16'h0002);
        end
        $display("test default edges done");
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 2'h0 : 2'($random(seed));
            // fall rows kept below the row width
            f = (i == 0) ? 2'h0 : 2'($random(seed));
            run_frame(16'h8080 | (16'(f) << 8) | 16'(r));
            compare_val("early rise", riseGap, rise_lead(r));
            compare_val("rows early", lineCount, 16'h0002);
            compare_val("early fall", 16'(lvAfterFall > 0 && lvAfterFall <= fall_lead(f)), 16'h0001);
        end
        $display("test early edges done");
        reg_write(8'h1f, 16'h0000);
        wait_line();
        reg_write(8'h0d, 16'h0002);
        repeat (3) @(posedge clock);
        cnt = 0;
        while (pixelOut.frameValid !== 1'b1 && cnt < 200) begin
            @(posedge clock);
            #1 cnt++;
        end
        compare_val("integration wait", 16'(cnt >= 30 && cnt <= 40), 16'h0001);
        wait_frame(30);
        compare_val("rows after restart", lineCount, 16'h0002);
        $display("test restart done");
        reg_write(8'h1f, 16'h8080);
        wait_line();
        reg_write(8'h0d, 16'h0001);
        compare_val("in reset", 16'(coreInReset), 16'h0001);
        reg_read(8'h1f, rd);
        compare_val("edge default", rd, 16'h0000);
        reg_write(8'h1f, 16'h0081);
        reg_read(8'h03, rd);
        compare_val("width default", rd, 16'h0040);
        reg_read(8'h1f, rd);
        compare_val("edge write ignored", rd, 16'h0000);
        compare_val("idle port", 16'(pixelOut), 16'h0000);
        reg_read(8'h0d, rd);
        compare_val("reset register", rd, 16'h0001);
        reg_write(8'h0d, 16'h0000);
        compare_val("reset cleared", 16'(coreInReset), 16'h0000);
        wait_frame(0);
        compare_val("rise after reset", riseGap, 16'h0006);
        compare_val("rows after reset", lineCount, 16'h0030);
        $display("test soft reset done");
        wait_line();
        reg_write(8'h0d, 16'h0004);
        compare_val("standby flag", 16'(standbyActive), 16'h0001);
        repeat (100) @(posedge clock);
        compare_val("standby idle", 16'(pixelOut), 16'h0000);
        reg_read(8'h0d, rd);
        compare_val("standby read", rd, 16'h0004);
        reg_write(8'h0d, 16'h0000);
        wait_frame(0);
        compare_val("rows after standby", lineCount, 16'h0030);
        $display("test standby done");
        tally_and_finish();
    end
endmodule
